/* bench/flash_array_model.sv */
/*
 Flash array stand-in: read data derived from the address, and a
 cmd_done pulse a fixed time after each issued command.
 Assumes the controller's clock, reset and command pulse.
*/
module flash_array_model #(
   parameter int DONE_DELAY = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [19:0] flash_rd_addr,
   input wire flash_ctrl_pkg::cmd_req_t cmd_out,
   output logic [31:0] flash_rd_data,
   output logic cmd_done
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt_q;
   logic [7:0] cnt_d;
   // ****************************************
   // Array data and command completion
   // ****************************************
   assign flash_rd_data = {12'ha5c, flash_rd_addr};
   always_comb begin
      cnt_d = cnt_q;
      if (cmd_out.valid) begin
         cnt_d = 8'(DONE_DELAY);
      end else if (cnt_q != 8'h00) begin
         cnt_d = cnt_q - 8'h01;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 8'h00;
         cmd_done <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         cmd_done <= (cnt_q == 8'h01);
      end
   end
endmodule

/* bench/testbench.sv */
/*
 Self-checking bench of the flash front end over APB.
 Assumes the flash array model and the package register map.
*/
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [19:0] mode_a = flash_ctrl_pkg::FLASH_MODE_OFS;
   localparam logic [19:0] cmd_a = flash_ctrl_pkg::FLASH_CMD_OFS;
   localparam logic [19:0] stat_a = flash_ctrl_pkg::FLASH_STATUS_OFS;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic write_protect = 1'b0, pready, pslverr, cmd_done, mc_irq, err;
   logic [19:0] paddr = 20'h0, flash_rd_addr;
   logic [31:0] pwdata = 32'h0, prdata, flash_rd_data, latch_rd_data, rd;
   logic [3:0] pstrb = 4'hf;
   logic [5:0] latch_rd_idx = 6'h0;
   logic [7:0] codes [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h0b, 8'h0d, 8'h0f};
   flash_ctrl_pkg::cmd_req_t cmd_out, last_cmd;
   int miscompares = 0, samples_checked = 0, cmd_seen = 0, n, w;

   flash_write_command_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .write_protect(write_protect),
      .flash_rd_addr(flash_rd_addr), .flash_rd_data(flash_rd_data), .cmd_out(cmd_out),
      .cmd_done(cmd_done), .latch_rd_idx(latch_rd_idx), .latch_rd_data(latch_rd_data),
      .mc_irq(mc_irq));
   flash_array_model array (.pclk(pclk), .presetn(presetn), .flash_rd_addr(flash_rd_addr),
      .cmd_out(cmd_out), .flash_rd_data(flash_rd_data), .cmd_done(cmd_done));

   // ****************************************
   // Clock, command monitor and tasks
   // ****************************************
   initial forever #2 pclk = ~pclk;
   always @(posedge pclk) begin
      if (cmd_out.valid === 1'b1) begin
         cmd_seen++;
         last_cmd = cmd_out;
      end
   end
   task automatic summarize();
      $display("checks %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [19:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 40);
      if (pready !== 1'b1) begin
         check(32'(pready), 32'h1);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic latch_read(input logic [5:0] i);
      @(posedge pclk);
      latch_rd_idx <= i;
      repeat (2) @(posedge pclk);
      rd = latch_rd_data;
   endtask
   task automatic run_cmd(input logic [7:0] code, input logic ie);
      w = cmd_seen;
      apb(1'b1, cmd_a, {16'h0, code ^ 8'h5a, code});
      check(32'(err), 32'h0);
      apb(1'b0, stat_a, 32'h0);
      check(rd & 32'h1, 32'h0);
      check(32'(cmd_seen), 32'(w + 1));
      check({16'h0, last_cmd.arg, last_cmd.code}, {16'h0, code ^ 8'h5a, code});
      apb(1'b1, cmd_a, 32'h01);
      check(32'(err), 32'h1);
      n = 0;
      while (mc_irq !== 1'b1 && n < 40) begin
         @(posedge pclk);
         n++;
      end
      check(32'(mc_irq), 32'(ie));
      apb(1'b0, stat_a, 32'h0);
      check(rd & 32'h7, 32'h5);
      @(posedge pclk);
      check(32'(mc_irq), 32'h0);
   endtask

   // ****************************************
   // Tests
   // ****************************************
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, stat_a, 32'h0);
      check(rd & 32'h1, 32'h1);
      check(32'(mc_irq), 32'h0);
      $display("test reset done");
      for (int f = 0; f < 4; f++) begin
         apb(1'b1, mode_a, 32'(f) << 8);
         for (int k = 0; k < 4; k++) begin
            apb(1'b0, 20'h00100 + 20'(4 * k), 32'h0);
            check(32'(n), 32'(2 + ((k % 2 == 1 && f >= 2) ? 0 : f)));
            check(rd, {12'ha5c, 20'h00100 + 20'(4 * k)});
         end
         apb(1'b1, 20'h00040, 32'h0);
         check(32'(n), 32'(f == 3 ? 5 : f + 3));
      end
      $display("test wait states done");
      apb(1'b1, 20'h23f14, 32'hcafe0005);
      check(32'(err), 32'h0);
      latch_read(6'h05);
      check(rd, 32'hcafe0005);
      apb(1'b1, 20'h00114, 32'hbeef0005);
      latch_read(6'h05);
      check(rd, 32'hbeef0005);
      apb(1'b1, 20'h00018, 32'h00060006);
      write_protect <= 1'b1;
      apb(1'b1, 20'h00018, 32'hdead0006);
      check(32'(err), 32'h1);
      write_protect <= 1'b0;
      latch_read(6'h06);
      check(rd, 32'h00060006);
      $display("test latch done");
      apb(1'b1, mode_a, 32'h1);
      for (int k = 0; k < 8; k++) begin
         run_cmd(codes[k], 1'b1);
      end
      apb(1'b1, mode_a, 32'h0);
      run_cmd(8'h01, 1'b0);
      $display("test commands done");
      w = cmd_seen;
      apb(1'b1, cmd_a, 32'h05);
      repeat (3) @(posedge pclk);
      apb(1'b0, stat_a, 32'h0);
      check(rd & 32'h3, 32'h3);
      check(32'(cmd_seen), 32'(w));
      apb(1'b0, 20'h8000c, 32'h0);
      check(32'(err), 32'h1);
      $display("test refusals done");
      summarize();
   end
   initial begin
      repeat (20000) @(posedge pclk);
      miscompares++;
      summarize();
   end
endmodule

/* hdl/flash_ctrl_pkg.sv */
/*
 Constants, types and the register map of the embedded flash front end.
 Assumes a 32-bit APB master and a flash array that reports command completion.
*/
package flash_ctrl_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam int ADDR_W = 20;
   localparam logic [19:0] REG_BASE = 20'h80000;
   localparam logic [19:0] FLASH_MODE_OFS = 20'h80000;
   localparam logic [19:0] FLASH_CMD_OFS = 20'h80004;
   localparam logic [19:0] FLASH_STATUS_OFS = 20'h80008;
   localparam logic [1:0] FLASH_AREA_TAG = 2'h0;

   // ****************************************
   // Fields and reset values
   // ****************************************
   localparam int MODE_RDY_IE_BIT = 0;
   localparam int MODE_WAIT_LSB = 8;
   localparam int CMD_CODE_LSB = 0;
   localparam int CMD_ARG_LSB = 8;
   localparam int STAT_IDLE_BIT = 0;
   localparam int STAT_ERR_BIT = 1;
   localparam int STAT_PEND_BIT = 2;
   localparam logic [1:0] WAIT_STATES_RESET = 2'h0;
   localparam logic RDY_IE_RESET = 1'b0;
   localparam int LATCH_WORDS = 64;
   localparam int LATCH_IDX_W = 6;

   // ****************************************
   // Command codes
   // ****************************************
   localparam logic [7:0] WRITE_PAGE_CMD = 8'h01;
   localparam logic [7:0] LOCK_SECTOR_CMD = 8'h02;
   localparam logic [7:0] PAGE_WRITE_LOCK_CMD = 8'h03;
   localparam logic [7:0] UNLOCK_SECTOR_CMD = 8'h04;
   localparam logic [7:0] ERASE_WHOLE_CMD = 8'h08;
   localparam logic [7:0] GP_BIT_SET_CMD = 8'h0b;
   localparam logic [7:0] GP_BIT_RESET_CMD = 8'h0d;
   localparam logic [7:0] SECURE_BIT_CMD = 8'h0f;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_DONE = 2'b10
   } bus_state_t;

   typedef struct packed {
      logic valid;
      logic [7:0] code;
      logic [7:0] arg;
   } cmd_req_t;

endpackage

/* hdl/flash_write_command_ctrl.sv */
/*
 APB slave front end of the embedded flash unit: wait-state timing,
 write latch buffer, command decoder and ready flag.
 Assumes APB signals synchronous to pclk and a flash array that pulses
 cmd_done when the command it was given has finished.
*/
// Implementation choices: the APB slave port and the register addresses.
// Overview of operation
// (RQ1) With wait states 2 or 3, sequential reads alternate full and single-cycle
// (RQ2) Flash writes land in a latch decoded by low 8 address bits, aliased
// (RQ3) Latch writes are refused while memory protection forbids them
// (RQ4) Master writes the latch with full 32-bit words only
// (RQ5) Writes take read wait states plus one, except at setting 3
// (RQ6) Codes 0x01 page write, 0x03 write and lock, 0x08 erase all
// (RQ7) Code 0x02 sets a sector lock, 0x04 clears it
// (RQ8) Codes 0x0b, 0x0d set and clear GP bit, 0x0f secures
// (RQ9) Software starts an operation by writing the command code field
// (RQ10) Ready flag drops as soon as the command register is written
// (RQ11) Ready flag rises again when the running command finishes
// (RQ12) With ready interrupt enabled, the rising ready flag raises the interrupt
// (RQ13) After reset the ready flag reads set
module flash_write_command_ctrl #(
   parameter int LATCH_DEPTH = flash_ctrl_pkg::LATCH_WORDS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [19:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic write_protect,
   output logic [19:0] flash_rd_addr,
   input wire logic [31:0] flash_rd_data,
   output flash_ctrl_pkg::cmd_req_t cmd_out,
   input wire logic cmd_done,
   input wire logic [5:0] latch_rd_idx,
   output logic [31:0] latch_rd_data,
   output logic mc_irq
);

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [1:0] access_waits(input logic [1:0] ws, input logic wr,
                                                input logic short_rd);
      if (wr) begin
         access_waits = (ws == 2'h3) ? 2'h3 : ws + 2'h1; // RQ5
      end else if (short_rd) begin
         access_waits = 2'h0; // RQ1
      end else begin
         access_waits = ws;
      end
   endfunction

   function automatic logic code_known(input logic [7:0] c);
      case (c)
         flash_ctrl_pkg::WRITE_PAGE_CMD,
         flash_ctrl_pkg::PAGE_WRITE_LOCK_CMD,
         flash_ctrl_pkg::ERASE_WHOLE_CMD: code_known = 1'b1; // RQ6
         flash_ctrl_pkg::LOCK_SECTOR_CMD,
         flash_ctrl_pkg::UNLOCK_SECTOR_CMD: code_known = 1'b1; // RQ7
         flash_ctrl_pkg::GP_BIT_SET_CMD,
         flash_ctrl_pkg::GP_BIT_RESET_CMD,
         flash_ctrl_pkg::SECURE_BIT_CMD: code_known = 1'b1; // RQ8
         default: code_known = 1'b0;
      endcase
   endfunction

   // ****************************************
   // Bus state
   // ****************************************
   flash_ctrl_pkg::bus_state_t state_q, state_d;
   logic [1:0] cnt_q, cnt_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;
   logic [31:0] prdata_q, prdata_d;
   logic [19:0] frd_addr_q, frd_addr_d;
   logic [19:0] last_addr_q, last_addr_d;
   logic last_valid_q, last_valid_d;
   logic seq_short_q, seq_short_d;
   logic [1:0] wait_states_q, wait_states_d;
   logic rdy_ie_q, rdy_ie_d;
   logic idle_q, idle_d;
   logic run_q, run_d;
   logic err_q, err_d;
   logic pend_q, pend_d;
   logic irq_q, irq_d;
   flash_ctrl_pkg::cmd_req_t cmd_q, cmd_d;
   logic [31:0] latch_mem [LATCH_DEPTH];
   logic [31:0] latch_rd_q;

   logic setup;
   logic done;
   logic in_flash;
   logic seq_rd;
   logic is_mode;
   logic is_cmd;
   logic is_stat;
   logic latch_we;
   logic cmd_wr;

   always_comb begin
      setup = psel && !penable;
      done = psel && penable && pready_q && (state_q == flash_ctrl_pkg::ST_DONE);
      in_flash = paddr[19:18] == flash_ctrl_pkg::FLASH_AREA_TAG;
      is_mode = paddr == flash_ctrl_pkg::FLASH_MODE_OFS;
      is_cmd = paddr == flash_ctrl_pkg::FLASH_CMD_OFS;
      is_stat = paddr == flash_ctrl_pkg::FLASH_STATUS_OFS;
      seq_rd = last_valid_q && (paddr == last_addr_q + 20'h4);
      latch_we = done && pwrite && in_flash && !pslverr_q;
      cmd_wr = done && pwrite && is_cmd && !pslverr_q;
   end

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      pready_d = 1'b0;
      pslverr_d = pslverr_q;
      prdata_d = prdata_q;
      frd_addr_d = frd_addr_q;
      last_addr_d = last_addr_q;
      last_valid_d = last_valid_q;
      seq_short_d = seq_short_q;
      case (state_q)
         flash_ctrl_pkg::ST_IDLE: begin
            if (setup) begin
               state_d = flash_ctrl_pkg::ST_WAIT;
               pslverr_d = 1'b0;
               cnt_d = 2'h0;
               if (in_flash) begin
                  frd_addr_d = paddr;
                  if (pwrite) begin
                     cnt_d = access_waits(wait_states_q, 1'b1, 1'b0); // RQ5
                     last_valid_d = 1'b0;
                     pslverr_d = write_protect; // RQ3
                  end else begin
                     // Alternate long and short only when wait states are 2 or 3
                     cnt_d = access_waits(wait_states_q, 1'b0,
                                          wait_states_q[1] && seq_rd && seq_short_q); // RQ1
                     seq_short_d = !(wait_states_q[1] && seq_rd && seq_short_q); // RQ1
                     last_addr_d = paddr;
                     last_valid_d = 1'b1;
                  end
               end else begin
                  last_valid_d = 1'b0;
                  pslverr_d = !(is_mode || is_cmd || is_stat) ||
                              (pwrite && is_stat) || (pwrite && is_cmd && !idle_q);
               end
            end
         end
         flash_ctrl_pkg::ST_WAIT: begin
            if (cnt_q == 2'h0) begin
               state_d = flash_ctrl_pkg::ST_DONE;
               pready_d = 1'b1;
               prdata_d = 32'h0;
               if (!pwrite && !pslverr_q) begin
                  if (in_flash) begin
                     prdata_d = flash_rd_data;
                  end else if (is_mode) begin
                     prdata_d[flash_ctrl_pkg::MODE_RDY_IE_BIT] = rdy_ie_q;
                     prdata_d[flash_ctrl_pkg::MODE_WAIT_LSB +: 2] = wait_states_q;
                  end else if (is_cmd) begin
                     prdata_d[flash_ctrl_pkg::CMD_CODE_LSB +: 8] = cmd_q.code;
                     prdata_d[flash_ctrl_pkg::CMD_ARG_LSB +: 8] = cmd_q.arg;
                  end else begin
                     prdata_d[flash_ctrl_pkg::STAT_IDLE_BIT] = idle_q;
                     prdata_d[flash_ctrl_pkg::STAT_ERR_BIT] = err_q;
                     prdata_d[flash_ctrl_pkg::STAT_PEND_BIT] = pend_q;
                  end
               end
            end else begin
               cnt_d = cnt_q - 2'h1;
            end
         end
         flash_ctrl_pkg::ST_DONE: begin
            state_d = flash_ctrl_pkg::ST_IDLE;
         end
         default: begin
            state_d = flash_ctrl_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= flash_ctrl_pkg::ST_IDLE;
         cnt_q <= 2'h0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0;
         frd_addr_q <= 20'h0;
         last_addr_q <= 20'h0;
         last_valid_q <= 1'b0;
         seq_short_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q <= prdata_d;
         frd_addr_q <= frd_addr_d;
         last_addr_q <= last_addr_d;
         last_valid_q <= last_valid_d;
         seq_short_q <= seq_short_d;
      end
   end

   // ****************************************
   // Write latch buffer
   // ****************************************
   // Only address bits 7:2 select a word, so the latch aliases across the area
   always_ff @(posedge pclk) begin
      if (latch_we) begin
         latch_mem[paddr[7:2]] <= pwdata; // RQ2
      end
      latch_rd_q <= latch_mem[latch_rd_idx];
   end

   // ****************************************
   // Mode, command and ready flag
   // ****************************************
   always_comb begin
      wait_states_d = wait_states_q;
      rdy_ie_d = rdy_ie_q;
      idle_d = idle_q;
      run_d = run_q;
      err_d = err_q;
      pend_d = pend_q;
      cmd_d = cmd_q;
      cmd_d.valid = 1'b0;
      if (done && pwrite && is_mode) begin
         wait_states_d = pwdata[flash_ctrl_pkg::MODE_WAIT_LSB +: 2];
         rdy_ie_d = pwdata[flash_ctrl_pkg::MODE_RDY_IE_BIT];
      end
      if (done && !pwrite && is_stat) begin
         err_d = 1'b0;
         pend_d = 1'b0;
      end
      if (run_q && cmd_done) begin
         run_d = 1'b0;
         idle_d = 1'b1; // RQ11
         pend_d = 1'b1; // RQ12
      end else if (!run_q && !idle_q) begin
         idle_d = 1'b1; // RQ11
         pend_d = 1'b1; // RQ12
      end
      if (cmd_wr) begin
         idle_d = 1'b0; // RQ10
         cmd_d.code = pwdata[flash_ctrl_pkg::CMD_CODE_LSB +: 8]; // RQ9
         cmd_d.arg = pwdata[flash_ctrl_pkg::CMD_ARG_LSB +: 8];
         if (code_known(pwdata[flash_ctrl_pkg::CMD_CODE_LSB +: 8])) begin
            cmd_d.valid = 1'b1; // RQ6 RQ7 RQ8
            run_d = 1'b1;
         end else begin
            err_d = 1'b1;
         end
      end
   end

   always_comb begin
      irq_d = pend_d && rdy_ie_d; // RQ12
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_states_q <= flash_ctrl_pkg::WAIT_STATES_RESET;
         rdy_ie_q <= flash_ctrl_pkg::RDY_IE_RESET;
         idle_q <= 1'b1; // RQ13
         run_q <= 1'b0;
         err_q <= 1'b0;
         pend_q <= 1'b0;
         irq_q <= 1'b0;
         cmd_q <= '0;
      end else begin
         wait_states_q <= wait_states_d;
         rdy_ie_q <= rdy_ie_d;
         idle_q <= idle_d;
         run_q <= run_d;
         err_q <= err_d;
         pend_q <= pend_d;
         irq_q <= irq_d;
         cmd_q <= cmd_d;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign flash_rd_addr = frd_addr_q;
   assign cmd_out = cmd_q;
   assign latch_rd_data = latch_rd_q;
   assign mc_irq = irq_q;

   // ****************************************
   // Checks
   // ****************************************
   chk_short_seq_read: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
      state_q == flash_ctrl_pkg::ST_IDLE && setup && in_flash && !pwrite && wait_states_q[1]
      && seq_rd && seq_short_q |=> cnt_q == 2'h0)
      else $error("short sequential read not single cycle");
   chk_long_seq_read: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
      state_q == flash_ctrl_pkg::ST_IDLE && setup && in_flash && !pwrite
      && !(wait_states_q[1] && seq_rd && seq_short_q)
      |=> cnt_q == $past(wait_states_q) && seq_short_q)
      else $error("long read wait count wrong");
   chk_latch_alias: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
      latch_we |=> latch_mem[$past(paddr[7:2])] == $past(pwdata))
      else $error("latch word not written at aliased index");
   chk_protect_block: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
      state_q == flash_ctrl_pkg::ST_IDLE && setup && in_flash && pwrite && write_protect
      |=> pslverr_q ##[2:4] (pready_q && pslverr_q && !latch_we))
      else $error("protected latch write not refused");
   chk_write_waits: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
      state_q == flash_ctrl_pkg::ST_IDLE && setup && in_flash && pwrite
      |=> cnt_q == (($past(wait_states_q) == 2'h3) ? 2'h3 : $past(wait_states_q) + 2'h1))
      else $error("write wait count wrong");
   chk_cmd_issue: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
      cmd_wr && code_known(pwdata[7:0])
      |=> cmd_q.valid && cmd_q.code == $past(pwdata[7:0]) ##1 !cmd_q.valid)
      else $error("known command not issued as one pulse");
   chk_bad_code: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
      cmd_wr && !code_known(pwdata[7:0]) |=> !cmd_q.valid && err_q ##1 idle_q)
      else $error("unknown command not rejected");
   chk_idle_drop: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
      cmd_wr |=> !idle_q)
      else $error("ready flag did not drop on command write");
   chk_idle_rise: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
      run_q && cmd_done && !cmd_wr |=> idle_q && !run_q)
      else $error("ready flag did not rise on completion");
   chk_irq_rise: assert property (@(posedge pclk) disable iff (!presetn) // RQ12
      $rose(idle_q) && rdy_ie_q && !$past(cmd_wr) |-> pend_q ##0 irq_q)
      else $error("interrupt not raised on ready rise");
   chk_idle_rest: assert property (@(posedge pclk) disable iff (!presetn) // RQ13
      !run_q && !$past(cmd_wr) |-> idle_q)
      else $error("ready flag low with nothing pending");

endmodule
